// [rtl/universal_serial_shifter.sv]
`timescale 1ns/10ps
// Summary of operation
// - Eight-bit shift register, MSB drives output pin.
// - Output latch changes opposite the sampling edge.
// - Input always sampled from the data pin.
// - Polarity bit swaps sample and shift edges.
// - External clock counts both serial clock edges.
// - Overflow flag set on counter wrap 15-0.
// - Completed byte copied into receive buffer.
// - Start flag from start condition or edges.
// - Start flag write-one clear releases hold.
// - Overflow flag write-one clear releases hold.
// - Start wakes always, overflow only idle.
// - Stop flag set on stop, no interrupt.
// - Collision reads MSB differing from pin.
// - Status low nibble reads, loads counter.
// - Counter clocked by selected clock source.
// - Toggle strobe clocks counter when selected.
// - External clock counts even with outputs off.
// - Enabled pending flag raises request immediately.
// - Wire mode changes the outputs and the start and stop detection.
// - Mode zero leaves pins under port control.
// - Three-wire output overrides port data bit.
module universal_serial_shifter
  import serial_shifter_pkg::*;
(
  // System clock and synchronous reset.
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  // APB slave.
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Data input pin, also the two-wire data line.
  input  wire logic        SERIAL_INPUT_PIN_IN,
  output logic             SERIAL_INPUT_PIN_OUT,
  output logic             SERIAL_INPUT_PIN_OE_OUT,
  // Serial clock pin, also the two-wire clock line.
  input  wire logic        SERIAL_CLOCK_PIN_IN,
  output logic             SERIAL_CLOCK_PIN_OUT,
  output logic             SERIAL_CLOCK_PIN_OE_OUT,
  output logic             CLOCK_TOGGLE_OUT,
  // Data output pin and the port bits that own it.
  input  wire logic        PORT_DATA_BIT_IN,
  input  wire logic        PORT_DIR_BIT_IN,
  output logic             DATA_OUTPUT_PIN_OUT,
  output logic             DATA_OUTPUT_PIN_OE_OUT,
  output logic             DATA_OUTPUT_PULLUP_OUT,
  // Timer compare match and sleep state.
  input  wire logic        TIMER_MATCH_IN,
  input  wire logic        SLEEP_IDLE_IN,
  // Interrupt requests and wake-up.
  output logic             START_IRQ_OUT,
  output logic             OVERFLOW_IRQ_OUT,
  output logic             WAKE_OUT
);

  // Control register fields.
  logic          start_irq_enable;
  logic          overflow_irq_enable;
  wire_mode_t    wire_mode_select;
  clock_source_t clock_source_select;
  logic          software_clock_select;

  // Status flags and data registers.
  logic          start_condition_flag;
  logic          counter_overflow_flag;
  logic          stop_condition_flag;
  logic          output_collision_flag;
  logic [3:0]    edge_counter_value;
  logic [7:0]    shift_data_register;
  logic [7:0]    receive_buffer_register;
  logic          sampled_bit;
  logic          output_latch;

  // Synchronised pins and edge history.
  logic [1:0]    pins_sync;
  logic          data_pin;
  logic          clock_pin;
  logic          data_pin_d;
  logic          clock_pin_d;
  logic          clock_rise;
  logic          clock_fall;
  logic          sample_edge;
  logic          shift_edge;
  logic          start_detect;
  logic          stop_detect;

  // Bus decode.
  logic          setup_phase;
  logic          write_access;
  logic          ctrl_write;
  logic          stat_write;
  logic          data_write;
  logic          addr_mapped;
  logic          sw_clock_pulse;
  logic          toggle_pulse;
  logic [7:0]    ctrl_read;
  logic [7:0]    stat_read;
  logic [7:0]    next_read;

  // Clocking of shift register and counter.
  logic          ext_clock;
  logic          two_wire;
  logic          shift_now;
  logic          shift_in;
  logic          count_inc;
  logic          count_wrap;
  logic [7:0]    next_shift;
  logic          latch_open;
  logic          clock_hold;

  // The data and clock pins cross into the system clock domain.
  pin_synchronizer #(
    .WIDTH   (SYNC_STAGES)
  ) u_sync (
    .clk_in  (CLK_SYS_IN),
    .rst_in  (RST_IN),
    .async_in({SERIAL_CLOCK_PIN_IN, SERIAL_INPUT_PIN_IN}),
    .sync_out(pins_sync)
  );

  assign data_pin  = pins_sync[0];
  assign clock_pin = pins_sync[1];

  // Delayed copies of the synchronised pins for edge detection.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      data_pin_d  <= 1'b0;
      clock_pin_d <= 1'b0;
    end else begin
      data_pin_d  <= data_pin;
      clock_pin_d <= clock_pin;
    end
  end

  // Edges of the serial clock and the two-wire bus conditions.
  assign clock_rise   = clock_pin && !clock_pin_d;
  assign clock_fall   = !clock_pin && clock_pin_d;
  assign start_detect = two_wire && clock_pin && clock_pin_d && data_pin_d && !data_pin;
  assign stop_detect  = two_wire && clock_pin && clock_pin_d && !data_pin_d && data_pin;

  // Polarity bit picks which edge samples and which edge shifts.
  assign sample_edge = clock_source_select[0] ? clock_fall : clock_rise;
  assign shift_edge  = clock_source_select[0] ? clock_rise : clock_fall;

  // Bus access decode; the slave never inserts wait states.
  assign setup_phase  = PSEL_IN && !PENABLE_IN;
  assign write_access = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign ctrl_write   = write_access && (PADDR_IN == CTRL_ADDR);
  assign stat_write   = write_access && (PADDR_IN == STAT_ADDR);
  assign data_write   = write_access && (PADDR_IN == DATA_ADDR);
  assign PREADY_OUT   = 1'b1;

  // Strobe bits act only in the cycle of the write.
  assign sw_clock_pulse = ctrl_write && PWDATA_IN[SW_CLK_BIT];
  assign toggle_pulse   = ctrl_write && PWDATA_IN[TOGGLE_BIT];

  // Address map check for the error answer.
  always_comb begin
    if (PADDR_IN == CTRL_ADDR) begin
      addr_mapped = 1'b1;
    end else if (PADDR_IN == STAT_ADDR) begin
      addr_mapped = 1'b1;
    end else if (PADDR_IN == DATA_ADDR) begin
      addr_mapped = 1'b1;
    end else if (PADDR_IN == BUF_ADDR) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  end

  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_mapped;

  // Control readback; the two strobe bits always read zero.
  assign ctrl_read = {start_irq_enable, overflow_irq_enable,
                      wire_mode_select, clock_source_select, 2'b00};

  // Status readback with the live counter value.
  assign stat_read = {start_condition_flag, counter_overflow_flag,
                      stop_condition_flag, output_collision_flag,
                      edge_counter_value};

  // Read data is picked in the setup cycle and held for the access cycle.
  always_comb begin
    if (PADDR_IN == CTRL_ADDR) begin
      next_read = ctrl_read;
    end else if (PADDR_IN == STAT_ADDR) begin
      next_read = stat_read;
    end else if (PADDR_IN == DATA_ADDR) begin
      next_read = shift_data_register;
    end else if (PADDR_IN == BUF_ADDR) begin
      next_read = receive_buffer_register;
    end else begin
      next_read = REG_RESET;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (setup_phase) begin
      PRDATA_OUT <= {24'h00_0000, next_read};
    end
  end

  // Control register; the software clock choice is kept for the counter.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      start_irq_enable      <= 1'b0;
      overflow_irq_enable   <= 1'b0;
      wire_mode_select      <= WM_OFF;
      clock_source_select   <= CS_SOFT;
      software_clock_select <= 1'b0;
    end else if (ctrl_write) begin
      start_irq_enable      <= PWDATA_IN[START_IE_BIT];
      overflow_irq_enable   <= PWDATA_IN[OVF_IE_BIT];
      wire_mode_select      <= wire_mode_t'(PWDATA_IN[WM_LSB +: 2]);
      clock_source_select   <= clock_source_t'(PWDATA_IN[CS_LSB +: 2]);
      software_clock_select <= PWDATA_IN[SW_CLK_BIT];
    end
  end

  assign ext_clock = clock_source_select[1];
  assign two_wire  = wire_mode_select[1];

  // Shift and count requests from the selected source.
  // The wire mode takes no part here, so inputs work in every mode.
  always_comb begin
    shift_now = 1'b0;
    shift_in  = data_pin;
    count_inc = 1'b0;
    case (clock_source_select)
      CS_SOFT: begin
        shift_now = sw_clock_pulse;
        count_inc = sw_clock_pulse;
      end
      CS_TIMER: begin
        shift_now = TIMER_MATCH_IN;
        count_inc = TIMER_MATCH_IN;
      end
      default: begin
        shift_now = shift_edge;
        shift_in  = sampled_bit;
        if (software_clock_select) begin
          count_inc = toggle_pulse;
        end else begin
          count_inc = clock_rise || clock_fall;
        end
      end
    endcase
  end

  // Next content of the shift register, used for the buffer copy too.
  assign next_shift = shift_now ? {shift_data_register[6:0], shift_in}
                                : shift_data_register;

  // The four-bit edge counter with software load.
  edge_counter #(
    .WIDTH        (4)
  ) u_counter (
    .clk_in       (CLK_SYS_IN),
    .rst_in       (RST_IN),
    .inc_in       (count_inc),
    .load_in      (stat_write),
    .load_value_in(PWDATA_IN[3:0]),
    .count_out    (edge_counter_value),
    .wrap_out     (count_wrap)
  );

  // Input bit captured on the sampling edge of the external clock.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      sampled_bit <= 1'b0;
    end else if (ext_clock && sample_edge) begin
      sampled_bit <= data_pin;
    end
  end

  // Shift register; a software write wins over a shift.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      shift_data_register <= REG_RESET;
    end else if (data_write) begin
      shift_data_register <= PWDATA_IN[7:0];
    end else begin
      shift_data_register <= next_shift;
    end
  end

  // Receive buffer takes the completed byte when the counter wraps.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      receive_buffer_register <= REG_RESET;
    end else if (count_wrap) begin
      receive_buffer_register <= next_shift;
    end
  end

  // With the external clock the latch is open only in the clock phase that follows shifting; otherwise always.
  assign latch_open = ext_clock ? (clock_pin == clock_source_select[0]) : 1'b1;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      output_latch <= 1'b0;
    end else if (latch_open) begin
      output_latch <= shift_data_register[7];
    end
  end

  // Start flag: set by start condition or clock edges, set wins over clear.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      start_condition_flag <= 1'b0;
    end else if (start_detect ||
                 (!two_wire && ext_clock && !software_clock_select &&
                  (clock_rise || clock_fall))) begin
      start_condition_flag <= 1'b1;
    end else if (stat_write && PWDATA_IN[START_BIT]) begin
      start_condition_flag <= 1'b0;
    end
  end

  // Overflow flag: set on wrap, cleared by writing one.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      counter_overflow_flag <= 1'b0;
    end else if (count_wrap) begin
      counter_overflow_flag <= 1'b1;
    end else if (stat_write && PWDATA_IN[OVF_BIT]) begin
      counter_overflow_flag <= 1'b0;
    end
  end

  // Stop flag: two-wire stop condition, cleared by writing one.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      stop_condition_flag <= 1'b0;
    end else if (stop_detect) begin
      stop_condition_flag <= 1'b1;
    end else if (stat_write && PWDATA_IN[STOP_BIT]) begin
      stop_condition_flag <= 1'b0;
    end
  end

  // Collision compares the register MSB with the sampled data line.
  assign output_collision_flag = shift_data_register[7] != data_pin;

  // Clock line held low after a start, and after overflow in hold mode.
  assign clock_hold = !clock_pin &&
                      ((two_wire && start_condition_flag) ||
                       (wire_mode_select == WM_TWO_HOLD && counter_overflow_flag));

  // Pin drivers, registered; the wire mode acts here and in start and stop detection.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      DATA_OUTPUT_PIN_OUT     <= 1'b0;
      DATA_OUTPUT_PIN_OE_OUT  <= 1'b0;
      DATA_OUTPUT_PULLUP_OUT  <= 1'b0;
      SERIAL_INPUT_PIN_OUT    <= 1'b0;
      SERIAL_INPUT_PIN_OE_OUT <= 1'b0;
      SERIAL_CLOCK_PIN_OUT    <= 1'b0;
      SERIAL_CLOCK_PIN_OE_OUT <= 1'b0;
      CLOCK_TOGGLE_OUT        <= 1'b0;
    end else begin
      DATA_OUTPUT_PIN_OE_OUT  <= PORT_DIR_BIT_IN;
      DATA_OUTPUT_PULLUP_OUT  <= !PORT_DIR_BIT_IN && PORT_DATA_BIT_IN;
      SERIAL_INPUT_PIN_OUT    <= 1'b0;
      SERIAL_CLOCK_PIN_OUT    <= 1'b0;
      CLOCK_TOGGLE_OUT        <= toggle_pulse;
      case (wire_mode_select)
        WM_OFF: begin
          DATA_OUTPUT_PIN_OUT     <= PORT_DATA_BIT_IN;
          SERIAL_INPUT_PIN_OE_OUT <= 1'b0;
          SERIAL_CLOCK_PIN_OE_OUT <= 1'b0;
        end
        WM_THREE: begin
          DATA_OUTPUT_PIN_OUT     <= output_latch;
          SERIAL_INPUT_PIN_OE_OUT <= 1'b0;
          SERIAL_CLOCK_PIN_OE_OUT <= 1'b0;
        end
        default: begin
          DATA_OUTPUT_PIN_OUT     <= PORT_DATA_BIT_IN;
          SERIAL_INPUT_PIN_OE_OUT <= !output_latch;
          SERIAL_CLOCK_PIN_OE_OUT <= clock_hold;
        end
      endcase
    end
  end

  // Requests follow flag and enable, so a pending flag fires at once.
  assign START_IRQ_OUT    = start_condition_flag && start_irq_enable;
  assign OVERFLOW_IRQ_OUT = counter_overflow_flag && overflow_irq_enable;

  // Start wakes from any sleep; overflow only from idle.
  assign WAKE_OUT = START_IRQ_OUT || (OVERFLOW_IRQ_OUT && SLEEP_IDLE_IN);

endmodule // universal_serial_shifter

// [shared/serial_shifter_pkg.sv]
package serial_shifter_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0]  CTRL_IDX      = 8'h0d;
  localparam logic [7:0]  STAT_IDX      = 8'h0e;
  localparam logic [7:0]  DATA_IDX      = 8'h0f;
  localparam logic [7:0]  BUF_IDX       = 8'h10;
  localparam logic [11:0] CTRL_ADDR     = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR     = {2'h0, STAT_IDX, 2'h0};
  localparam logic [11:0] DATA_ADDR     = {2'h0, DATA_IDX, 2'h0};
  localparam logic [11:0] BUF_ADDR      = {2'h0, BUF_IDX, 2'h0};

  // Status register field positions.
  localparam int          START_BIT     = 7;
  localparam int          OVF_BIT       = 6;
  localparam int          STOP_BIT      = 5;
  localparam int          COLL_BIT      = 4;

  // Control register field positions.
  localparam int          START_IE_BIT  = 7;
  localparam int          OVF_IE_BIT    = 6;
  localparam int          WM_LSB        = 4;
  localparam int          CS_LSB        = 2;
  localparam int          SW_CLK_BIT    = 1;
  localparam int          TOGGLE_BIT    = 0;

  // Values after reset and counter limits.
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  localparam logic [3:0]  CNT_MAX       = 4'hf;
  localparam int          SYNC_STAGES   = 2;

  // Wire modes of the output stage.
  typedef enum logic [1:0] {
    WM_OFF,
    WM_THREE,
    WM_TWO,
    WM_TWO_HOLD
  } wire_mode_t;

  // Clock sources of the shift register and counter.
  typedef enum logic [1:0] {
    CS_SOFT,
    CS_TIMER,
    CS_EXT_POS,
    CS_EXT_NEG
  } clock_source_t;

endpackage

// [rtl/pin_synchronizer.sv]
`timescale 1ns/10ps
module pin_synchronizer #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Asynchronous levels and their synchronised copies.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Two flip-flops per bit; only the second stage is read outside.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule // pin_synchronizer

// [rtl/edge_counter.sv]
`timescale 1ns/10ps
module edge_counter
  import serial_shifter_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Count and load requests.
  input  wire logic             inc_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] load_value_in,
  // Count value and wrap pulse.
  output logic      [WIDTH-1:0] count_out,
  output logic                  wrap_out
);

  // A wrap is an increment taken while the count is at its top value.
  assign wrap_out = inc_in && !load_in && (count_out == {WIDTH{1'b1}});

  // A load from software wins over a counted clock.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_out <= WIDTH'(CNT_RESET);
    end else if (load_in) begin
      count_out <= load_value_in;
    end else if (inc_in) begin
      count_out <= count_out + WIDTH'(1);
    end
  end

endmodule // edge_counter

// [tb/universal_serial_shifter_assertions.sv]
`timescale 1ns/10ps
module universal_serial_shifter_assertions
  import serial_shifter_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  // Pins and requests.
  input wire logic        PORT_DATA_BIT_IN,
  input wire logic        PORT_DIR_BIT_IN,
  input wire logic        DATA_OUTPUT_PIN_OUT,
  input wire logic        DATA_OUTPUT_PIN_OE_OUT,
  input wire logic        DATA_OUTPUT_PULLUP_OUT,
  input wire logic        SERIAL_INPUT_PIN_OE_OUT,
  input wire logic        SERIAL_CLOCK_PIN_OE_OUT,
  input wire logic        CLOCK_TOGGLE_OUT,
  input wire logic        SLEEP_IDLE_IN,
  input wire logic        START_IRQ_OUT,
  input wire logic        OVERFLOW_IRQ_OUT,
  input wire logic        WAKE_OUT
);
  logic       acc;
  logic [1:0] wm;
  logic       clr_st;
  logic       clr_ov;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  // A write takes effect in its access phase.
  assign acc = PSEL_IN && PENABLE_IN && PWRITE_IN;

  // Wire mode as last written.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      wm <= 2'h0;
    end else if (acc && PADDR_IN == CTRL_ADDR) begin
      wm <= PWDATA_IN[WM_LSB+:2];
    end
  end

  // Writes that may lawfully drop a request.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      clr_st <= 1'b0;
      clr_ov <= 1'b0;
    end else begin
      clr_st <= acc && ((PADDR_IN == STAT_ADDR && PWDATA_IN[START_BIT]) ||
                        (PADDR_IN == CTRL_ADDR && !PWDATA_IN[START_IE_BIT]));
      clr_ov <= acc && ((PADDR_IN == STAT_ADDR && PWDATA_IN[OVF_BIT]) ||
                        (PADDR_IN == CTRL_ADDR && !PWDATA_IN[OVF_IE_BIT]));
    end
  end

  chk_wake_start: assert property (START_IRQ_OUT |-> WAKE_OUT)
    else $error("start request without wake");
  chk_wake_idle: assert property (
    !START_IRQ_OUT |-> WAKE_OUT == (OVERFLOW_IRQ_OUT && SLEEP_IDLE_IN))
    else $error("wake does not follow overflow and idle");
  chk_toggle_pulse: assert property (
    acc && PADDR_IN == CTRL_ADDR && PWDATA_IN[TOGGLE_BIT]
    |=> CLOCK_TOGGLE_OUT ##1 !CLOCK_TOGGLE_OUT)
    else $error("toggle strobe is not a single pulse");
  chk_strobe_zero: assert property (
    PSEL_IN && PENABLE_IN && !PWRITE_IN && PADDR_IN == CTRL_ADDR |-> PRDATA_OUT[1:0] == 2'h0)
    else $error("strobe bits read back nonzero");
  chk_start_sticky: assert property ($fell(START_IRQ_OUT) |-> clr_st)
    else $error("start request dropped without a clearing write");
  chk_ovf_sticky: assert property ($fell(OVERFLOW_IRQ_OUT) |-> clr_ov)
    else $error("overflow request dropped without a clearing write");
  chk_off_pins: assert property (
    wm == 2'h0 && $past(wm) == 2'h0 && !$past(RST_IN) |-> !SERIAL_INPUT_PIN_OE_OUT &&
    !SERIAL_CLOCK_PIN_OE_OUT && DATA_OUTPUT_PIN_OUT == $past(PORT_DATA_BIT_IN))
    else $error("pins not under port control with outputs off");
  chk_dir_drives: assert property (
    wm == 2'h1 && !$past(RST_IN) |-> DATA_OUTPUT_PIN_OE_OUT == $past(PORT_DIR_BIT_IN))
    else $error("data output enable does not follow direction bit");
  chk_pullup_port: assert property (
    !$past(RST_IN) |-> DATA_OUTPUT_PULLUP_OUT == $past(!PORT_DIR_BIT_IN && PORT_DATA_BIT_IN))
    else $error("pull-up does not follow the port bits");
endmodule  // universal_serial_shifter_assertions

bind universal_serial_shifter universal_serial_shifter_assertions chk_i (
  .CLK_SYS_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN,
  .PRDATA_OUT, .PORT_DATA_BIT_IN, .PORT_DIR_BIT_IN, .DATA_OUTPUT_PIN_OUT,
  .DATA_OUTPUT_PIN_OE_OUT, .DATA_OUTPUT_PULLUP_OUT, .SERIAL_INPUT_PIN_OE_OUT,
  .SERIAL_CLOCK_PIN_OE_OUT,
  .CLOCK_TOGGLE_OUT, .SLEEP_IDLE_IN, .START_IRQ_OUT, .OVERFLOW_IRQ_OUT, .WAKE_OUT
);

// [tb/serial_peer_model.sv]
`timescale 1ns/10ps
module serial_peer_model #(
  parameter int HALF_NS = 400
) (
  // Serial clock and data towards the block.
  output logic      sclk_out,
  output logic      sdat_out,
  // Data returned by the block.
  input  wire logic sdo_in
);
  // Clock rests low between frames.
  initial begin
    sclk_out = 1'b0;
    sdat_out = 1'b1;
  end

  // One byte, MSB first, two clock edges per bit, eight bits.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #37;
    for (int i = 7; i >= 0; i--) begin
      sdat_out = tx[i];
      #(HALF_NS);
      sclk_out = 1'b1;
      #(HALF_NS - 50);
      rx[i] = sdo_in;
      #50;
      sclk_out = 1'b0;
    end
    sdat_out = ~tx[0];  // Released line shows the inverse of the last bit.
  endtask

  // Start (stop low) or stop (stop high): data moves while the clock is high.
  // The clock is left low after a start and high after a stop, as on a real bus.
  task automatic bus_cond(input logic stop);
    #37;
    sdat_out = ~stop;
    #(HALF_NS);
    sclk_out = 1'b1;
    #(HALF_NS);
    sdat_out = stop;
    #(HALF_NS);
    sclk_out = stop;
    #(HALF_NS);
  endtask
endmodule  // serial_peer_model

// [tb/tb.sv]
`timescale 1ns/10ps
module tb
  import serial_shifter_pkg::*;
;
  logic        clk, rst, psel, pen, pwr, pdat, pdir, tmr, idle, rnd, er, perr, pready;
  logic        si_oe, sc_oe, do_o, sirq, oirq, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  tx, rx, dv, cr;
  wire         si_w, sc_w, p_sclk, p_sdat;
  int          n_fail, num_checks, cyc;

  // Open-drain lines: a low from the block wins over the peer.
  assign si_w = si_oe ? 1'b0 : p_sdat;
  assign sc_w = sc_oe ? 1'b0 : p_sclk;

  universal_serial_shifter universal_serial_shifter_i (
    .CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(perr), .SERIAL_INPUT_PIN_IN(si_w), .SERIAL_INPUT_PIN_OUT(),
    .SERIAL_INPUT_PIN_OE_OUT(si_oe), .SERIAL_CLOCK_PIN_IN(sc_w), .SERIAL_CLOCK_PIN_OUT(),
    .SERIAL_CLOCK_PIN_OE_OUT(sc_oe), .CLOCK_TOGGLE_OUT(), .PORT_DATA_BIT_IN(pdat),
    .PORT_DIR_BIT_IN(pdir), .DATA_OUTPUT_PIN_OUT(do_o), .DATA_OUTPUT_PIN_OE_OUT(),
    .DATA_OUTPUT_PULLUP_OUT(), .TIMER_MATCH_IN(tmr), .SLEEP_IDLE_IN(idle),
    .START_IRQ_OUT(sirq), .OVERFLOW_IRQ_OUT(oirq), .WAKE_OUT(wake)
  );

  serial_peer_model serial_peer_model_i (.sclk_out(p_sclk), .sdat_out(p_sdat), .sdo_in(do_o));

  // System clock.
  always #50 clk = ~clk;

  // Cycle ceiling against a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  // Sleep state and direction bit wander at random, the port data bit once enabled.
  always @(posedge clk) begin
    idle <= 1'($urandom);
    pdir <= 1'($urandom);
    if (rnd) begin
      pdat <= 1'($urandom);
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Main sequence.
  initial begin
    {clk, psel, pen, pwr, pdat, pdir, tmr, idle, rnd} = '0;
    rst = 1'b1;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(32'h02ad0727));
    repeat (4) @(posedge clk);
    rst  <= 1'b0;
    rdchk(CTRL_ADDR, 32'h0);
    // The data register resets to zero while the idle data line is high.
    rdchk(STAT_ADDR, 32'h10);
    rdchk(12'h000, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Frames from the peer: three-wire with random bytes, then outputs off with corners.
    for (int k = 0; k < 2; k++) begin
      cr = k ? 8'h08 : 8'h18;
      dv = k ? 8'h01 : 8'($urandom);
      tx = k ? 8'hfe : 8'($urandom);
      apb(1'b1, CTRL_ADDR, {24'h0, cr});
      apb(1'b1, DATA_ADDR, {24'h0, dv});
      apb(1'b1, STAT_ADDR, 32'he0);
      serial_peer_model_i.xfer(tx, rx);
      repeat (8) @(posedge clk);
      chk({24'h0, rx}, {24'h0, k ? 8'h00 : dv});
      rdchk(BUF_ADDR, {24'h0, tx});
      rdchk(DATA_ADDR, {24'h0, tx});
      rdchk(STAT_ADDR, {24'h0, 3'h6, tx[7] ^ ~tx[0], 4'h0});
      @(negedge clk);
      chk({31'h0, sirq | oirq}, 32'h0);
      apb(1'b1, CTRL_ADDR, {24'h0, cr | 8'hc0});
      @(negedge clk);
      chk({29'h0, sirq, oirq, wake}, 32'h7);
      apb(1'b1, STAT_ADDR, 32'h80);
      @(negedge clk);
      chk({29'h0, sirq, oirq, wake}, {29'h0, 2'b01, idle});
      apb(1'b1, STAT_ADDR, 32'h40);
      rdchk(STAT_ADDR, {27'h0, tx[7] ^ ~tx[0], 4'h0});
    end
    // Outputs off with port bits wandering: timer, software and toggle clocking.
    rnd <= 1'b1;
    apb(1'b1, CTRL_ADDR, 32'h04);
    apb(1'b1, STAT_ADDR, 32'h4e);
    repeat (2) begin
      @(posedge clk);
      tmr <= 1'b1;
      @(posedge clk);
      tmr <= 1'b0;
    end
    rdchk(STAT_ADDR, 32'h40);
    apb(1'b1, STAT_ADDR, 32'h45);
    // A strobe counts under the source in force before its own write, so the
    // first of these falls under the timer source and is not counted.
    repeat (3) apb(1'b1, CTRL_ADDR, 32'h02);
    rdchk(STAT_ADDR, 32'h07);
    rdchk(CTRL_ADDR, 32'h0);
    // The first write still strobes the soft source; the next two toggle.
    apb(1'b1, CTRL_ADDR, 32'h0a);
    repeat (2) apb(1'b1, CTRL_ADDR, 32'h0b);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk(rd & 32'hef, 32'h0a);
    // Two-wire mode: a start holds the clock low until cleared, a stop sets its flag.
    apb(1'b1, DATA_ADDR, 32'hff);
    apb(1'b1, CTRL_ADDR, 32'h20);
    apb(1'b1, STAT_ADDR, 32'he0);
    serial_peer_model_i.bus_cond(1'b0);
    rdchk(STAT_ADDR, 32'h90);
    chk({31'h0, sc_oe}, 32'h1);
    apb(1'b1, STAT_ADDR, 32'h80);
    repeat (2) @(negedge clk);
    chk({31'h0, sc_oe}, 32'h0);
    serial_peer_model_i.bus_cond(1'b1);
    rdchk(STAT_ADDR, 32'h20);
    results();
  end
endmodule  // tb
